// >>> verilog/baf_pkg.sv
// constants and types for the byte alu with status flags
//******************************************************************
// Operation
// RULE_01: eight bit add, subtract, shift, logic
// RULE_02: accumulator combined with any file register
// RULE_03: arithmetic in two's complement form
// RULE_04: instruction selects which flags update
// RULE_05: subtract carry flags mean borrow out; the code sets them when no borrow occurs
// RULE_06: signed wrap beyond 127 or -128
// RULE_07: signed wrap from bit6 bit7 carries
// RULE_08: unsigned 8x8 product in one cycle
// RULE_09: accumulator and counter mapped in memory
// RULE_10: file to file move bypasses accumulator
// RULE_11: 16-bit fetch overlapped with execute
// RULE_12: single cycle except branches, table moves
// RULE_13: nil flag set when result zero
// RULE_14: add carries from bit3 and bit7
//******************************************************************
package baf_pkg;
  localparam int DW = 8;
  localparam int IW = 16;
  localparam int AW = 8;
  localparam int PCW = 16;
  localparam int NIB = 4;
  localparam logic [AW-1:0] ADDR_ACC = 8'h0A;
  localparam logic [AW-1:0] ADDR_PCL = 8'h02;
  localparam logic [AW-1:0] ADDR_FLAGS = 8'h04;
  localparam logic [AW-1:0] ADDR_PRODL = 8'h18;
  localparam logic [AW-1:0] ADDR_PRODH = 8'h19;
  localparam logic [DW-1:0] ACC_RESET = 8'h00;
  localparam logic [PCW-1:0] PC_RESET = 16'h0000;
  localparam logic [PCW-1:0] PC_STEP = 16'h0001;
  localparam int F_BORROW = 0;
  localparam int F_NIBBLE = 1;
  localparam int F_NIL = 2;
  localparam int F_WRAP = 3;
  // opcode [15:12] op, [11] dest to file, [7:0] file address or literal
  localparam int OP_HI = 15;
  localparam int OP_LO = 12;
  localparam int DEST_BIT = 11;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_AND = 4'h3,
    OP_IOR = 4'h4, OP_XOR = 4'h5, OP_RLC = 4'h6, OP_RRC = 4'h7,
    OP_MUL = 4'h8, OP_MOVFF = 4'h9, OP_LIT_SUB = 4'hA, OP_GOTO = 4'hB,
    OP_TBLRD = 4'hC, OP_MOVWF = 4'hD, OP_MOVF = 4'hE, OP_TBLWT = 4'hF
  } baf_op_type;
  typedef struct packed {
    logic [DW-1:0] result;
    logic borrow;
    logic nibble;
    logic nil;
    logic wrap;
  } baf_alu_out_type;
  typedef enum logic [1:0] {ST_RUN = 2'b00, ST_STALL = 2'b01} baf_state_type;
endpackage

// >>> verilog/baf_adder.sv
// two's complement byte adder with carry and overflow taps
`timescale 1ns/1ps
module baf_adder (
  input wire logic [baf_pkg::DW-1:0] a,
  input wire logic [baf_pkg::DW-1:0] b,
  input wire logic cin,
  output logic [baf_pkg::DW-1:0] sum,
  output logic c_nib,
  output logic c_out,
  output logic wrap
);
  import baf_pkg::*;
  wire [NIB:0] lo = {1'b0, a[NIB-1:0]} + {1'b0, b[NIB-1:0]} + {{NIB{1'b0}}, cin};
  wire [DW-NIB:0] hi = {1'b0, a[DW-1:NIB]} + {1'b0, b[DW-1:NIB]} + {{(DW-NIB){1'b0}}, lo[NIB]};
  wire c_into7 = a[DW-1] ^ b[DW-1] ^ hi[DW-NIB-1];
  assign sum = {hi[DW-NIB-1:0], lo[NIB-1:0]}; // RULE_03
  assign c_nib = lo[NIB]; // RULE_14
  assign c_out = hi[DW-NIB]; // RULE_14
  // only bits 6 and 7 of this byte count; wider signed math must ignore it
  assign wrap = c_into7 ^ hi[DW-NIB]; // RULE_07
endmodule

// >>> verilog/baf_core.sv
// byte alu datapath with status flags, multiplier and fetch pipeline
`timescale 1ns/1ps
module baf_core (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [baf_pkg::IW-1:0] instr_word,
  output logic [baf_pkg::PCW-1:0] fetch_addr,
  output logic [baf_pkg::AW-1:0] file_addr,
  output logic [baf_pkg::AW-1:0] file_dst_addr,
  input wire logic [baf_pkg::DW-1:0] file_rdata,
  output logic [baf_pkg::DW-1:0] file_wdata,
  output logic file_we,
  output logic [baf_pkg::DW-1:0] acc_out,
  output logic [3:0] flags_out,
  output logic [2*baf_pkg::DW-1:0] product_out,
  output logic stall_out,
  input wire logic [baf_pkg::AW-1:0] reg_addr,
  input wire logic [baf_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [baf_pkg::DW-1:0] reg_rdata
);
  import baf_pkg::*;
  //******************************************************************
  // pipeline
  //******************************************************************
  logic [IW-1:0] exec_q, exec_d;
  logic [PCW-1:0] pc_q, pc_d;
  baf_state_type st_q, st_d;
  logic [DW-1:0] acc_q, acc_d;
  logic [3:0] flags_q, flags_d;
  logic [2*DW-1:0] prod_q, prod_d;
  logic [AW-1:0] fa_q, fda_q;
  logic [DW-1:0] fw_q;
  logic fwe_q;
  logic [DW-1:0] rdata_q;
  logic stall_q;
  wire baf_op_type op = baf_op_type'(exec_q[OP_HI:OP_LO]);
  wire to_file = exec_q[DEST_BIT];
  wire [DW-1:0] lit = exec_q[DW-1:0];
  wire two_cycle = (op == OP_GOTO) || (op == OP_TBLRD) || (op == OP_TBLWT); // RULE_12
  wire in_run = (st_q == ST_RUN);
  // file operand arrives combinationally from the register file
  wire [DW-1:0] fop = file_rdata; // RULE_02
  // move target sits in bits 11:8, so a move reaches only the low sixteen registers
  wire [AW-1:0] move_dst = {{(AW-NIB){1'b0}}, exec_q[DEST_BIT -: NIB]}; // RULE_10
  //******************************************************************
  // arithmetic
  //******************************************************************
  wire is_sub = (op == OP_SUB) || (op == OP_LIT_SUB);
  wire [DW-1:0] minuend = (op == OP_LIT_SUB) ? lit : fop;
  wire [DW-1:0] add_a = is_sub ? minuend : fop;
  wire [DW-1:0] add_b = is_sub ? ~acc_q : acc_q; // RULE_03
  wire [DW-1:0] sum;
  wire c_nib, c_out, v_out;
  baf_adder u_add (
    .a(add_a),
    .b(add_b),
    .cin(is_sub),
    .sum(sum),
    .c_nib(c_nib),
    .c_out(c_out),
    .wrap(v_out)
  );
  baf_alu_out_type arith;
  assign arith = '{result: sum, borrow: c_out, nibble: c_nib, nil: (sum == '0), wrap: v_out};
  wire [2*DW-1:0] mul = {{DW{1'b0}}, acc_q} * {{DW{1'b0}}, fop}; // RULE_08
  logic [DW-1:0] res;
  logic res_valid;
  logic [3:0] fl;
  always_comb begin
    res = fop;
    res_valid = 1'b0;
    fl = flags_q;
    case (op)
      OP_ADD, OP_SUB, OP_LIT_SUB: begin
        res = arith.result;
        res_valid = 1'b1;
        // on subtract a set carry means no borrow, as in two's complement
        fl[F_BORROW] = arith.borrow; // RULE_05
        fl[F_NIBBLE] = arith.nibble; // RULE_05
        fl[F_WRAP] = arith.wrap; // RULE_06
        fl[F_NIL] = arith.nil; // RULE_13
      end
      OP_AND, OP_IOR, OP_XOR: begin
        res = (op == OP_AND) ? (acc_q & fop) : (op == OP_IOR) ? (acc_q | fop) : (acc_q ^ fop); // RULE_01
        res_valid = 1'b1;
        fl[F_NIL] = (res == '0); // RULE_04
      end
      OP_RLC: begin
        res = {fop[DW-2:0], flags_q[F_BORROW]}; // RULE_01
        res_valid = 1'b1;
        fl[F_BORROW] = fop[DW-1];
      end
      OP_RRC: begin
        res = {flags_q[F_BORROW], fop[DW-1:1]};
        res_valid = 1'b1;
        fl[F_BORROW] = fop[0];
      end
      OP_MOVWF: begin
        res = acc_q;
        res_valid = 1'b1;
      end
      OP_MOVF: begin
        res = fop;
        res_valid = 1'b1;
        fl[F_NIL] = (fop == '0);
      end
      OP_MOVFF: begin
        res = fop;
        res_valid = 1'b1;
      end
      default: begin
        res = fop;
      end
    endcase
  end
  // file-to-file move writes the file straight back; accumulator untouched
  wire wr_file = in_run && res_valid && (to_file || (op == OP_MOVWF) || (op == OP_MOVFF)); // RULE_10
  wire wr_acc = in_run && res_valid && !wr_file;
  // software writes to mapped accumulator and flags take effect next cycle
  wire sw_acc = reg_wr && (reg_addr == ADDR_ACC); // RULE_09
  wire sw_flags = reg_wr && (reg_addr == ADDR_FLAGS);
  wire sw_pc = reg_wr && (reg_addr == ADDR_PCL);
  wire fwd_acc = wr_file && (op != OP_MOVFF) && (lit == ADDR_ACC);
  //******************************************************************
  // next state
  //******************************************************************
  always_comb begin
    st_d = st_q;
    pc_d = pc_q;
    exec_d = exec_q;
    case (st_q)
      ST_RUN: begin
        if (two_cycle) begin
          st_d = ST_STALL; // RULE_12
          exec_d = '0;
          pc_d = (op == OP_GOTO) ? {{(PCW-DW){1'b0}}, lit} : pc_q;
        end else begin
          exec_d = instr_word; // RULE_11
          pc_d = pc_q + PC_STEP;
        end
      end
      ST_STALL: begin
        st_d = ST_RUN;
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
    if (sw_pc) begin
      pc_d = {pc_q[PCW-1:DW], reg_wdata}; // RULE_09
    end
  end
  assign acc_d = sw_acc ? reg_wdata : (wr_acc || fwd_acc) ? res : acc_q;
  assign flags_d = sw_flags ? reg_wdata[3:0] : in_run ? fl : flags_q;
  assign prod_d = (in_run && op == OP_MUL) ? mul : prod_q;
  wire [DW-1:0] rsel = (reg_addr == ADDR_ACC) ? acc_q :
                       (reg_addr == ADDR_FLAGS) ? {4'h0, flags_q} :
                       (reg_addr == ADDR_PCL) ? pc_q[DW-1:0] :
                       (reg_addr == ADDR_PRODL) ? prod_q[DW-1:0] :
                       (reg_addr == ADDR_PRODH) ? prod_q[2*DW-1:DW] : 8'h00;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_RUN;
      pc_q <= PC_RESET;
      exec_q <= '0;
      acc_q <= ACC_RESET;
      flags_q <= 4'h0;
      prod_q <= '0;
    end else begin
      st_q <= st_d;
      pc_q <= pc_d;
      exec_q <= exec_d;
      acc_q <= acc_d;
      flags_q <= flags_d; // RULE_04
      prod_q <= prod_d;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fa_q <= '0;
      fda_q <= '0;
      fw_q <= '0;
      fwe_q <= 1'b0;
      rdata_q <= '0;
      stall_q <= 1'b0;
    end else begin
      fa_q <= exec_d[DW-1:0]; // RULE_02
      fda_q <= (op == OP_MOVFF) ? move_dst : lit; // RULE_10
      fw_q <= res;
      fwe_q <= wr_file;
      rdata_q <= reg_rd ? rsel : 8'h00;
      stall_q <= (st_d == ST_STALL);
    end
  end
  // the file address follows the executing word, so the operand always matches it
  assign fetch_addr = pc_q;
  assign file_addr = fa_q;
  assign file_dst_addr = fda_q;
  assign file_wdata = fw_q;
  assign file_we = fwe_q;
  assign acc_out = acc_q;
  assign flags_out = flags_q;
  assign product_out = prod_q;
  assign stall_out = stall_q;
  assign reg_rdata = rdata_q;
  //******************************************************************
  // checks
  //******************************************************************
  a_add_flags: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_14
    in_run && op == OP_ADD |=> flags_q[F_BORROW] == $past(c_out) || $past(sw_flags)) else $error("add carry wrong");
  a_sub_borrow: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_05
    in_run && op == OP_SUB && !sw_flags |=> flags_q[F_BORROW] == ($past(fop) >= $past(acc_q))) else $error("sub borrow wrong");
  a_wrap_flag: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_06
    in_run && op == OP_ADD && !sw_flags && fop[DW-1] == acc_q[DW-1] && sum[DW-1] != fop[DW-1] |=> flags_q[F_WRAP])
    else $error("wrap missed");
  a_nil_flag: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_13
    in_run && res_valid && op inside {OP_ADD, OP_SUB, OP_AND, OP_XOR} && !sw_flags |=> flags_q[F_NIL] == ($past(res) == 8'h00))
    else $error("nil flag wrong");
  a_mul_prod: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_08
    in_run && op == OP_MUL |=> prod_q == $past(acc_q) * $past(fop)) else $error("product wrong");
  a_stall_len: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_12
    in_run && two_cycle |=> stall_out ##1 !stall_out) else $error("stall length wrong");
  a_pc_step: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_11
    in_run && !two_cycle && !sw_pc |=> pc_q == $past(pc_q) + PC_STEP) else $error("fetch not overlapped");
  a_move_noacc: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_10
    in_run && op == OP_MOVFF && !sw_acc |=> acc_q == $past(acc_q) && file_we) else $error("move touched acc");
  a_acc_map: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_09
    sw_acc |=> acc_q == $past(reg_wdata)) else $error("acc map write lost");
  a_add_carry: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_14
    in_run && op == OP_ADD && !sw_flags
    |=> flags_q[F_BORROW] == (int'($past(fop)) + int'($past(acc_q)) >= (1 << DW)))
    else $error("add byte carry wrong");
  a_add_nibble: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_14
    in_run && op == OP_ADD && !sw_flags
    |=> flags_q[F_NIBBLE] == (int'($past(fop[NIB-1:0])) + int'($past(acc_q[NIB-1:0])) >= (1 << NIB)))
    else $error("add nibble carry wrong");
  a_sub_nibble: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_05
    in_run && op == OP_SUB && !sw_flags
    |=> flags_q[F_NIBBLE] == ($past(fop[NIB-1:0]) >= $past(acc_q[NIB-1:0])))
    else $error("sub nibble borrow wrong");
  a_lit_borrow: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_05
    in_run && op == OP_LIT_SUB && !sw_flags
    |=> flags_q[F_BORROW] == ($past(lit) >= $past(acc_q)))
    else $error("literal borrow wrong");
  a_wrap_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_06
    in_run && op == OP_ADD && !sw_flags && fop[DW-1] != acc_q[DW-1]
    |=> !flags_q[F_WRAP])
    else $error("wrap set on mixed signs");
  a_sub_wrap: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_07
    in_run && op == OP_SUB && !sw_flags && fop[DW-1] != acc_q[DW-1] && sum[DW-1] != fop[DW-1]
    |=> flags_q[F_WRAP])
    else $error("sub wrap missed");
  a_logic_keep: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_04
    in_run && op inside {OP_AND, OP_IOR, OP_XOR} && !sw_flags
    |=> flags_q[F_BORROW] == $past(flags_q[F_BORROW]) && flags_q[F_WRAP] == $past(flags_q[F_WRAP]))
    else $error("logic op touched carry");
  a_ior_nil: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_13
    in_run && op == OP_IOR && !sw_flags
    |=> flags_q[F_NIL] == (($past(fop) | $past(acc_q)) == '0))
    else $error("ior nil wrong");
  a_movf_nil: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_13
    in_run && op == OP_MOVF && !sw_flags
    |=> flags_q[F_NIL] == ($past(fop) == '0))
    else $error("move nil wrong");
  a_nop_flags: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_04
    in_run && op == OP_NOP && !sw_flags
    |=> flags_q == $past(flags_q))
    else $error("nop changed flags");
  a_rrc_carry: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_01
    in_run && op == OP_RRC && !sw_flags
    |=> flags_q[F_BORROW] == $past(fop[0]))
    else $error("rotate right carry wrong");
  //******************************************************************
  // result checks
  //******************************************************************
  a_add_result: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_01
    in_run && op == OP_ADD && !to_file && !sw_acc
    |=> acc_q == $past(fop) + $past(acc_q))
    else $error("add result wrong");
  a_sub_result: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_03
    in_run && op == OP_SUB && !to_file && !sw_acc
    |=> acc_q == $past(fop) - $past(acc_q))
    else $error("sub result wrong");
  a_lit_result: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_03
    in_run && op == OP_LIT_SUB && !to_file && !sw_acc
    |=> acc_q == $past(lit) - $past(acc_q))
    else $error("literal sub result wrong");
  a_and_result: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_02
    in_run && op == OP_AND && !to_file && !sw_acc
    |=> acc_q == ($past(fop) & $past(acc_q)))
    else $error("and result wrong");
  a_rlc_result: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_01
    in_run && op == OP_RLC && !to_file && !sw_acc
    |=> acc_q == {$past(fop[DW-2:0]), $past(flags_q[F_BORROW])})
    else $error("rotate left result wrong");
  a_file_write: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_02
    in_run && res_valid && to_file && op != OP_MOVFF
    |=> file_we && file_wdata == $past(res) && file_dst_addr == $past(lit))
    else $error("file write wrong");
  a_move_path: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_10
    in_run && op == OP_MOVFF
    |=> file_we && file_dst_addr == $past(move_dst) && file_wdata == $past(fop))
    else $error("move path wrong");
  a_no_write: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_02
    !(in_run && res_valid)
    |=> !file_we)
    else $error("stray file write");
  //******************************************************************
  // pipeline and register map checks
  //******************************************************************
  a_goto_target: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_12
    in_run && op == OP_GOTO && !sw_pc
    |=> fetch_addr == {{(PCW-DW){1'b0}}, $past(lit)})
    else $error("branch target wrong");
  a_stall_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_12
    stall_out && !sw_pc
    |=> fetch_addr == $past(fetch_addr))
    else $error("fetch moved in stall");
  a_stall_nop: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_11
    stall_out
    |-> op == OP_NOP)
    else $error("stall executes a word");
  a_fetch_take: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_11
    in_run && !two_cycle
    |=> exec_q == $past(instr_word))
    else $error("fetched word lost");
  a_prod_hold: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_08
    !(in_run && op == OP_MUL)
    |=> product_out == $past(product_out))
    else $error("product changed");
  a_flags_map: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_09
    sw_flags
    |=> flags_q == $past(reg_wdata[F_WRAP:F_BORROW]))
    else $error("flags map write lost");
  a_pc_map: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_09
    sw_pc
    |=> pc_q[DW-1:0] == $past(reg_wdata))
    else $error("counter map write lost");
  a_read_idle: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_09
    !reg_rd
    |=> reg_rdata == '0)
    else $error("read data without strobe");
  a_read_prod: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_08
    reg_rd && reg_addr == ADDR_PRODH
    |=> reg_rdata == $past(prod_q[2*DW-1:DW]))
    else $error("product read wrong");
  c_add: cover property (@(posedge core_clk) disable iff (!reset_n) in_run && op == OP_ADD && v_out);
  c_sub: cover property (@(posedge core_clk) disable iff (!reset_n) in_run && op == OP_SUB && !c_out);
  c_goto: cover property (@(posedge core_clk) disable iff (!reset_n) in_run && op == OP_GOTO);
  c_movff: cover property (@(posedge core_clk) disable iff (!reset_n) in_run && op == OP_MOVFF);
  c_rlc: cover property (@(posedge core_clk) disable iff (!reset_n) in_run && op == OP_RLC);
endmodule

// >>> sim/baf_partner.sv
// partner model: instruction source and file register memory
`timescale 1ns/1ps
module baf_partner (
  input wire logic core_clk,
  input wire logic [baf_pkg::AW-1:0] file_addr,
  input wire logic [baf_pkg::AW-1:0] file_dst_addr,
  input wire logic [baf_pkg::DW-1:0] file_wdata,
  input wire logic file_we,
  output logic [baf_pkg::DW-1:0] file_rdata,
  output logic [baf_pkg::IW-1:0] instr_word
);
  import baf_pkg::*;
  logic [DW-1:0] fmem [0:255];
  logic [IW-1:0] word_q;
  initial begin
    word_q = '0;
    for (int i = 0; i < 256; i++) begin
      fmem[i] = 8'h00;
    end
  end
  // operand answered in the same cycle from any file register
  assign file_rdata = fmem[file_addr];
  assign instr_word = word_q;
  // result written back to the file when the op asks for it
  always @(posedge core_clk) begin
    if (file_we) begin
      fmem[file_dst_addr] <= file_wdata;
    end
  end
endmodule

// >>> sim/byte_alu_status_flags_tb.sv
// self-checking bench for the byte alu core
`timescale 1ns/1ps
module byte_alu_status_flags_tb;
  import baf_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [AW-1:0] reg_addr = 8'h00;
  logic [DW-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [IW-1:0] instr_word;
  logic [PCW-1:0] fetch_addr;
  logic [AW-1:0] file_addr, file_dst_addr;
  logic [DW-1:0] file_rdata, file_wdata, acc_out, reg_rdata;
  logic file_we, stall_out;
  logic [3:0] flags_out;
  logic [2*DW-1:0] product_out;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  baf_op_type ops [7] = '{OP_ADD, OP_SUB, OP_LIT_SUB, OP_AND, OP_IOR, OP_XOR, OP_MUL};
  always #10 core_clk = ~core_clk;
  baf_core baf_core_i (.core_clk(core_clk), .reset_n(reset_n), .instr_word(instr_word),
    .fetch_addr(fetch_addr), .file_addr(file_addr), .file_dst_addr(file_dst_addr),
    .file_rdata(file_rdata), .file_wdata(file_wdata), .file_we(file_we), .acc_out(acc_out),
    .flags_out(flags_out), .product_out(product_out), .stall_out(stall_out), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  baf_partner baf_partner_i (.core_clk(core_clk), .file_addr(file_addr), .file_dst_addr(file_dst_addr),
    .file_wdata(file_wdata), .file_we(file_we), .file_rdata(file_rdata), .instr_word(instr_word));
  //****************************************
  // tasks
  //****************************************
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic reg_write(logic [7:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, taken at the edge closing it
  task automatic reg_read(logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  task automatic exercise(baf_op_type op, logic [7:0] a, logic [7:0] f, logic dest);
    logic [7:0] low, res, d;
    logic [7:0] b;
    logic c;
    logic [8:0] r;
    logic [4:0] n;
    logic [15:0] p;
    low = (op == OP_LIT_SUB) ? f : 8'h20;
    baf_partner_i.fmem[8'h20] = f;
    reg_write(ADDR_ACC, a);
    // a trailing nop keeps the pipeline quiet while results settle
    baf_partner_i.word_q <= {op, dest, 3'b000, low};
    @(posedge core_clk);
    baf_partner_i.word_q <= {8'h00, low};
    repeat (4) @(posedge core_clk);
    c = (op != OP_ADD);
    b = c ? ~a : a;
    r = {1'b0, f} + {1'b0, b} + c;
    n = {1'b0, f[3:0]} + {1'b0, b[3:0]} + c;
    p = {8'h00, f} * a;
    res = (op == OP_AND) ? (f & a) : (op == OP_IOR) ? (f | a) : (op == OP_XOR) ? (f ^ a) : r[7:0];
    if (op == OP_MUL) begin
      check("product", product_out, p);
      reg_read(ADDR_PRODH, d);
      check("prodh", d, p[15:8]);
    end else if (dest) begin
      check("file", baf_partner_i.fmem[8'h20], res);
      check("acc kept", acc_out, a);
    end else begin
      check("acc", acc_out, res);
      if (op inside {OP_ADD, OP_SUB, OP_LIT_SUB}) begin
        check("flags", flags_out, {(f[7] == b[7]) && (res[7] != f[7]), res == 8'h00, n[4], r[8]});
      end else begin
        check("nil", flags_out[F_NIL], res == 8'h00);
      end
      reg_read(ADDR_ACC, d);
      check("acc map", d, res);
    end
  endtask
  //****************************************
  // sequence
  //****************************************
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    logic [7:0] d;
    logic [15:0] pc;
    void'($urandom(58));
    repeat (11) @(posedge core_clk);
    check("reset acc", acc_out, 8'h00);
    @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    pc = fetch_addr;
    @(posedge core_clk);
    check("fetch step", fetch_addr, pc + PC_STEP);
    exercise(OP_ADD, 8'h01, 8'hFF, 1'b0);
    exercise(OP_ADD, 8'h01, 8'h7F, 1'b0);
    exercise(OP_SUB, 8'h01, 8'h80, 1'b0);
    exercise(OP_SUB, 8'h00, 8'h00, 1'b0);
    exercise(OP_LIT_SUB, 8'h10, 8'h0F, 1'b0);
    exercise(OP_ADD, 8'h0F, 8'h01, 1'b1);
    exercise(OP_MUL, 8'hFF, 8'hFF, 1'b0);
    for (int i = 0; i < 8; i++) begin
      foreach (ops[k]) begin
        exercise(ops[k], 8'($urandom), 8'($urandom), 1'b0);
      end
    end
    // rotate through a known carry, then a file to file move and a branch
    reg_write(ADDR_FLAGS, 8'h01);
    baf_partner_i.fmem[8'h20] = 8'h81;
    baf_partner_i.word_q <= {OP_RLC, 4'h0, 8'h20};
    @(posedge core_clk);
    baf_partner_i.word_q <= 16'h0000;
    repeat (4) @(posedge core_clk);
    check("rotate", acc_out, 8'h03);
    check("rotate carry", flags_out[F_BORROW], 1'b1);
    baf_partner_i.fmem[8'h20] = 8'h5A;
    baf_partner_i.word_q <= {OP_MOVFF, 4'h5, 8'h20};
    @(posedge core_clk);
    baf_partner_i.word_q <= 16'h0000;
    repeat (4) @(posedge core_clk);
    check("move file", baf_partner_i.fmem[8'h05], 8'h5A);
    check("move acc", acc_out, 8'h03);
    baf_partner_i.word_q <= {OP_GOTO, 4'h0, 8'h40};
    @(posedge core_clk);
    baf_partner_i.word_q <= 16'h0000;
    repeat (2) @(posedge core_clk);
    check("branch stall", stall_out, 1'b1);
    check("branch target", fetch_addr, 16'h0040);
    @(posedge core_clk);
    check("branch done", stall_out, 1'b0);
    reg_read(8'h33, d);
    check("unmapped", d, 8'h00);
    reg_write(ADDR_FLAGS, 8'h05);
    @(posedge core_clk);
    check("flags write", flags_out, 4'h5);
    finish_test();
  end
endmodule
